// File: hdl/power_good_and_reset_supervisor.sv
// Power-good combination, register reset control, rail mode and voltage code registers.
// Assumes an APB master on pclk; platform inputs are levels synchronised here.

module power_good_and_reset_supervisor #(
	parameter logic [6:0] VCODE_RESET = 7'h00
) (
	// Clock and reset
	input  wire logic                                 pclk,
	input  wire logic                                 presetn,
	// APB slave
	input  wire logic                                 psel,
	input  wire logic                                 penable,
	input  wire logic                                 pwrite,
	input  wire logic [supervisor_pkg::ADDR_W-1:0]    paddr,
	input  wire logic [supervisor_pkg::DATA_W-1:0]    pwdata,
	output logic      [supervisor_pkg::DATA_W-1:0]    prdata,
	output logic                                      pready,
	output logic                                      pslverr,
	// Supply, enable, sleep and thermal inputs
	input  wire logic                                 supply_run_ok,
	input  wire logic                                 supply_low,
	input  wire logic                                 device_enable_in,
	input  wire logic                                 thermal_trip_n,
	input  wire logic                                 deep_sleep_n,
	input  wire logic                                 standby_sleep_n,
	input  wire logic                                 idle_sleep_n,
	input  wire logic                                 crit_temp_shutdown,
	input  wire logic                                 ldo_one_always_on,
	// Rail status
	input  wire logic [supervisor_pkg::RAILS-1:0]     rail_good,
	input  wire logic [supervisor_pkg::RAILS-1:0]     rail_fault,
	// Power-good and control outputs
	output logic                                      suspend_reset_release,
	output logic                                      platform_power_ok,
	output logic                                      registers_reset,
	output logic [supervisor_pkg::RAILS-1:0]          rail_pwm_forced,
	output logic [supervisor_pkg::VOUTS-1:0][supervisor_pkg::MV_W-1:0] rail_target_mv,
	output logic                                      irq
);

	import supervisor_pkg::*;

	localparam int IN_W = 21;

	logic [IN_W-1:0]   raw_in;
	logic [IN_W-1:0]   sync_in;
	logic              run_s;
	logic              low_s;
	logic              en_s;
	logic              therm_s;
	logic              deep_s;
	logic              stby_s;
	logic              idle_s;
	logic              crit_s;
	logic              ldo_on_s;
	logic [RAILS-1:0]  good_s;
	logic [RAILS-1:0]  fault_s;

	// ----------------------------------------
	// Input synchronisation
	// ----------------------------------------
	assign raw_in = {supply_run_ok, supply_low, device_enable_in, thermal_trip_n, deep_sleep_n,
	                 standby_sleep_n, idle_sleep_n, crit_temp_shutdown, ldo_one_always_on,
	                 rail_good, rail_fault};

	input_sync #(.WIDTH(IN_W)) u_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.din   (raw_in),
		.dout  (sync_in)
	);

	assign {run_s, low_s, en_s, therm_s, deep_s, stby_s, idle_s, crit_s, ldo_on_s, good_s, fault_s} = sync_in;

	// ----------------------------------------
	// Edges, qualifiers and reset causes
	// ----------------------------------------
	logic [EDGES-1:0]  edge_prev_reg;
	logic [EDGES-1:0]  edge_prev_next;
	logic [EDGES-1:0]  falls;
	logic              en_fall;
	logic              therm_fall;
	logic              stby_fall;
	logic              idle_fall;
	logic              fault_any;
	logic              susp_base;
	logic              plat_base;
	logic              susp_q;
	logic              plat_q;
	logic              sw_shutdown;
	logic              full_reset;
	logic              core_reset;
	logic              wr_en;
	logic [RAILS-1:0]  fault_mask_reg;

	always_comb begin
		edge_prev_next = {en_s, therm_s, stby_s, idle_s};
		falls = edge_prev_reg & ~edge_prev_next;
		{en_fall, therm_fall, stby_fall, idle_fall} = falls;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			edge_prev_reg <= '0;
		end else begin
			edge_prev_reg <= edge_prev_next;
		end
	end

	// Faults are folded into the qualifiers so an output never outlives the fault by more than one edge.
	assign fault_any   = crit_s | (|(fault_s & ~fault_mask_reg));
	assign susp_base   = run_s & en_s & therm_s & (&(good_s | ~SUSPEND_RAILS));
	assign plat_base   = deep_s & stby_s & (&good_s);
	assign susp_q      = susp_base & ~fault_any & ~low_s;
	assign plat_q      = susp_q & plat_base;
	assign sw_shutdown = wr_en & (paddr == ADDR_SHUTDOWN) & pwdata[SHUTDOWN_BIT];
	assign full_reset  = low_s
	                   | (en_fall & ~ldo_on_s)
	                   | (therm_fall & suspend_reset_release)
	                   | fault_any
	                   | sw_shutdown;
	assign core_reset  = idle_fall | stby_fall;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	function automatic logic rail_hit(input logic [ADDR_W-1:0] a);
		rail_hit = (a >= ADDR_RAIL_BASE) && (a <= ADDR_RAIL_LAST) && (a[1:0] == 2'b00);
	endfunction : rail_hit

	function automatic logic [2:0] rail_index(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] off;
		off = a - ADDR_RAIL_BASE;
		rail_index = off[4:2];
	endfunction : rail_index

	logic [RAILS-1:0]   fault_mask_next;
	logic [IRQ_W-1:0]   irq_status_reg;
	logic [IRQ_W-1:0]   irq_status_next;
	logic [IRQ_W-1:0]   irq_en_reg;
	logic [IRQ_W-1:0]   irq_en_next;
	logic [IRQ_W-1:0]   irq_event;
	logic [IRQ_W-1:0]   irq_clr_wr;
	logic [CTRL_W-1:0]  rail_ctrl_reg [RAILS];
	logic [CTRL_W-1:0]  rail_ctrl_next [RAILS];
	logic [DATA_W-1:0]  rd_data;
	logic               hit;
	logic               setup;
	logic [19:0]        status_word;
	logic               irq_cause;

	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pready & pwrite;
	assign status_word = {fault_s, good_s, idle_s, stby_s, deep_s, therm_s, en_s, run_s,
	                      platform_power_ok, suspend_reset_release};

	always_comb begin
		rd_data = '0;
		hit = 1'b1;
		case (paddr)
			ADDR_FAULT_MASK: begin
				rd_data = DATA_W'(fault_mask_reg);
			end
			ADDR_SHUTDOWN, ADDR_IRQ_CLEAR: begin
				rd_data = '0;
			end
			ADDR_STATUS: begin
				rd_data = DATA_W'(status_word);
			end
			ADDR_IRQ_STATUS: begin
				rd_data = DATA_W'(irq_status_reg);
			end
			ADDR_IRQ_ENABLE: begin
				rd_data = DATA_W'(irq_en_reg);
			end
			default: begin
				if (rail_hit(paddr)) begin
					rd_data = DATA_W'(rail_ctrl_reg[rail_index(paddr)]);
				end else begin
					hit = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata  <= setup ? rd_data : '0;
			pready  <= setup;
			pslverr <= setup & ~hit;
		end
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	always_comb begin
		irq_event = '0;
		irq_event[IRQ_SUSP_LOST]  = suspend_reset_release & ~susp_q;
		irq_event[IRQ_PLAT_LOST]  = platform_power_ok & ~plat_q;
		irq_event[IRQ_CODE_RESET] = core_reset;
		irq_event[IRQ_MASKED_FLT] = |(fault_s & fault_mask_reg);
		irq_clr_wr = (wr_en && paddr == ADDR_IRQ_CLEAR) ? pwdata[IRQ_W-1:0] : '0;
		fault_mask_next = fault_mask_reg;
		irq_en_next = irq_en_reg;
		irq_status_next = (irq_status_reg & ~irq_clr_wr) | irq_event;
		for (int i = 0; i < RAILS; i++) begin
			rail_ctrl_next[i] = rail_ctrl_reg[i];
			if (wr_en && rail_hit(paddr) && rail_index(paddr) == 3'(i)) begin
				rail_ctrl_next[i] = pwdata[CTRL_W-1:0];
				rail_ctrl_next[i][MODE_BIT] = pwdata[MODE_BIT] & PWM_CAPABLE[i];
			end
			if (core_reset && CORE_RAILS[i]) begin
				rail_ctrl_next[i][CODE_W-1:0] = VCODE_RESET;
			end
		end
		if (wr_en && paddr == ADDR_FAULT_MASK) begin
			fault_mask_next = pwdata[RAILS-1:0];
		end
		if (wr_en && paddr == ADDR_IRQ_ENABLE) begin
			irq_en_next = pwdata[IRQ_W-1:0];
		end
		// A full reset wipes the pending events too; software sees the cleared file.
		if (full_reset) begin
			fault_mask_next = FAULT_MASK_RST;
			irq_en_next = IRQ_RST;
			irq_status_next = IRQ_RST;
			for (int i = 0; i < RAILS; i++) begin
				rail_ctrl_next[i] = {1'b0, VCODE_RESET};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_mask_reg <= FAULT_MASK_RST;
			irq_en_reg     <= IRQ_RST;
			irq_status_reg <= IRQ_RST;
			for (int i = 0; i < RAILS; i++) begin
				rail_ctrl_reg[i] <= {1'b0, VCODE_RESET};
			end
		end else begin
			fault_mask_reg <= fault_mask_next;
			irq_en_reg     <= irq_en_next;
			irq_status_reg <= irq_status_next;
			for (int i = 0; i < RAILS; i++) begin
				rail_ctrl_reg[i] <= rail_ctrl_next[i];
			end
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	logic [RAILS-1:0]             pwm_next;
	logic [VOUTS-1:0][MV_W-1:0]   mv_next;

	assign irq_cause = |(irq_status_reg & irq_en_reg);

	always_comb begin
		for (int i = 0; i < RAILS; i++) begin
			pwm_next[i] = rail_ctrl_reg[i][MODE_BIT] & PWM_CAPABLE[i];
		end
		for (int v = 0; v < VOUTS; v++) begin
			mv_next[v] = code_to_mv(rail_ctrl_reg[(v < 2) ? v : v + 2][CODE_W-1:0]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			suspend_reset_release <= 1'b0;
			platform_power_ok     <= 1'b0;
			registers_reset       <= 1'b0;
			rail_pwm_forced       <= '0;
			rail_target_mv        <= '0;
			irq                   <= 1'b0;
		end else begin
			suspend_reset_release <= susp_q;
			platform_power_ok     <= plat_q;
			registers_reset       <= full_reset;
			rail_pwm_forced       <= pwm_next;
			rail_target_mv        <= mv_next;
			irq                   <= irq_cause;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	susp_qualify_a: assert property (@(posedge pclk) disable iff (!presetn)
		suspend_reset_release |-> $past(susp_base) && $past(run_s) && $past(good_s[3]))
		else $error("suspend release high without its qualifiers");

	plat_qualify_a: assert property (@(posedge pclk) disable iff (!presetn)
		platform_power_ok |-> suspend_reset_release && $past(plat_base))
		else $error("platform power ok high without its qualifiers");

	drop_fast_a: assert property (@(posedge pclk) disable iff (!presetn)
		(fault_any || !en_s) |=> !suspend_reset_release && !platform_power_ok)
		else $error("power good not dropped one cycle after loss");

	supply_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
		low_s [*2] |-> registers_reset && fault_mask_reg == FAULT_MASK_RST)
		else $error("registers not held in reset on low supply");

	enable_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
		(en_fall && !ldo_on_s) |=> registers_reset && irq_en_reg == IRQ_RST)
		else $error("enable fall did not reset registers");

	therm_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
		(therm_fall && suspend_reset_release) |=> registers_reset)
		else $error("thermal trip fall did not reset registers");

	fault_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
		(|(fault_s & ~fault_mask_reg) || crit_s) |=> registers_reset)
		else $error("fault did not reset registers");

	sw_shutdown_a: assert property (@(posedge pclk) disable iff (!presetn)
		sw_shutdown |=> registers_reset && fault_mask_reg == FAULT_MASK_RST && irq_en_reg == IRQ_RST)
		else $error("software shutdown did not reset registers");

	core_code_a: assert property (@(posedge pclk) disable iff (!presetn)
		core_reset |=> rail_ctrl_reg[0][CODE_W-1:0] == VCODE_RESET && rail_ctrl_reg[1][CODE_W-1:0] == VCODE_RESET)
		else $error("core rail codes not reset on sleep edge");

	auto_only_a: assert property (@(posedge pclk) disable iff (!presetn)
		rail_pwm_forced[1:0] == 2'b00)
		else $error("core rails left auto mode");

	code_sat_a: assert property (@(posedge pclk) disable iff (!presetn)
		(rail_ctrl_reg[0][CODE_W-1:0] >= CODE_SAT) |=> rail_target_mv[0] == MV_SAT)
		else $error("voltage code did not saturate");

	set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
		(irq_event[IRQ_CODE_RESET] && irq_clr_wr[IRQ_CODE_RESET] && !full_reset)
		|=> irq_status_reg[IRQ_CODE_RESET])
		else $error("event lost against its clear");

endmodule : power_good_and_reset_supervisor

// File: hdl/supervisor_pkg.sv
// Constants, register map and code decoding for the power-good and reset supervisor.
// Assumes one 100 MHz clock, an APB master with 8-bit byte addresses and 32-bit data.
// Operation
// - The block drives two separate power-good outputs, each the AND of its own group of qualifiers.
// - The suspend-reset release goes high only with supply above the run level, enable and thermal-trip high and rails 1, 4 and 5 good.
// - The platform power-ok goes high only with every suspend qualifier, the deep-sleep and standby-sleep inputs high and rails 1 to 6 good.
// - Each power-good output drops at once when any qualifier is lost or any unmasked fault occurs.
// - All registers reset while the supply monitor reports the supply below the reset level.
// - A falling enable resets all registers unless the first low-voltage LDO is configured always on.
// - A falling thermal-trip resets all registers while the suspend-reset release is high.
// - An unmasked regulator power fault or a critical temperature shutdown resets all registers.
// - Writing 1 to the shutdown command bit performs a software shutdown that resets all registers.
// - The voltage codes of core rails one and two reset on a falling idle-sleep or standby-sleep input.
// - Rails 3 to 6 each have a mode bit in their control register choosing auto or forced PWM.
// - The mode bit resets to auto, where the regulator picks PWM or PFM from its load.
// - Rails 1 and 2 have no forced-PWM choice and stay in auto mode always.
// - For rails 1, 2, 5 and 6 code 0 gives 0 V, code 1 gives 0.50 V plus 10 mV per step, saturating at 1.67 V.

package supervisor_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int ADDR_W  = 8;
	localparam int DATA_W  = 32;
	localparam int RAILS   = 6;
	localparam int CTRL_W  = 8;
	localparam int CODE_W  = 7;
	localparam int MV_W    = 11;
	localparam int VOUTS   = 4;
	localparam int IRQ_W   = 4;
	localparam int EDGES   = 4;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_FAULT_MASK = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_SHUTDOWN   = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_STATUS     = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR  = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_RAIL_BASE  = 8'h20;
	localparam logic [ADDR_W-1:0] ADDR_RAIL_LAST  = 8'h34;

	// ----------------------------------------
	// Fields and reset values
	// ----------------------------------------
	localparam int                 MODE_BIT        = 7;
	localparam int                 SHUTDOWN_BIT    = 0;
	localparam logic [RAILS-1:0]   FAULT_MASK_RST  = 6'h00;
	localparam logic [IRQ_W-1:0]   IRQ_RST         = 4'h0;
	localparam logic [RAILS-1:0]   SUSPEND_RAILS   = 6'h19;
	localparam logic [RAILS-1:0]   PWM_CAPABLE     = 6'h3C;
	localparam logic [RAILS-1:0]   CORE_RAILS      = 6'h03;
	localparam int                 IRQ_SUSP_LOST   = 0;
	localparam int                 IRQ_PLAT_LOST   = 1;
	localparam int                 IRQ_CODE_RESET  = 2;
	localparam int                 IRQ_MASKED_FLT  = 3;

	// ----------------------------------------
	// Voltage code table, 10 mV steps
	// ----------------------------------------
	localparam logic [CODE_W-1:0]  CODE_ZERO = 7'h00;
	localparam logic [CODE_W-1:0]  CODE_ONE  = 7'h01;
	localparam logic [CODE_W-1:0]  CODE_SAT  = 7'h76;
	localparam logic [MV_W-1:0]    MV_FIRST  = 11'h1F4;
	localparam logic [MV_W-1:0]    MV_STEP   = 11'h00A;
	localparam logic [MV_W-1:0]    MV_SAT    = 11'h686;
	localparam logic [MV_W-1:0]    MV_ZERO   = 11'h000;

	function automatic logic [MV_W-1:0] code_to_mv(input logic [CODE_W-1:0] code);
		logic [CODE_W-1:0] steps;
		steps = code - CODE_ONE;
		if (code == CODE_ZERO) begin
			code_to_mv = MV_ZERO;
		end else if (code >= CODE_SAT) begin
			code_to_mv = MV_SAT;
		end else begin
			code_to_mv = MV_W'(MV_FIRST + MV_W'(MV_STEP * {4'h0, steps}));
		end
	endfunction : code_to_mv

endpackage : supervisor_pkg

// File: hdl/input_sync.sv
// Two flip-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; bits are not coherent with each other.

module input_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Levels
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			dout     <= '0;
		end else begin
			meta_reg <= din;
			dout     <= meta_reg;
		end
	end

endmodule : input_sync

// File: verification/platform_model.sv
// Platform model: the board logic that drives the supervisor's level inputs.
// Assumes the bench sets wanted levels on pclk edges; they reach the pins one edge later.
module platform_model (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Wanted levels
	input  wire logic [20:0] want,
	// Pin levels
	output logic      [20:0] lvl
);
	timeunit 1ns;
	timeprecision 1ps;

	// Pins change only on an edge, so the synchroniser delay is exact and repeatable.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lvl <= 21'h0_0000;
		end else begin
			lvl <= want;
		end
	end
endmodule : platform_model

// File: verification/testbench.sv
// Self-checking bench for the power-good and reset supervisor.
// Assumes zero-wait APB answers and a three-edge pin-to-output path.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import supervisor_pkg::*;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic                       pclk    = 1'b0;
	logic                       presetn = 1'b0;
	logic                       psel    = 1'b0;
	logic                       penable = 1'b0;
	logic                       pwrite  = 1'b0;
	logic [ADDR_W-1:0]          paddr   = 8'h00;
	logic [DATA_W-1:0]          pwdata  = 32'h0000_0000;
	logic [DATA_W-1:0]          prdata;
	logic                       pready, pslverr, susp, plat, rreset, irq;
	int                         rr_count = 0;
	logic [RAILS-1:0]           forced;
	logic [VOUTS-1:0][MV_W-1:0] mv;
	logic [20:0]                want    = 21'h0_0000;
	logic [20:0]                lvl;
	logic [20:0]                good_w  = 21'h0_7E7D;
	logic [6:0]                 codes [8] = '{7'h00, 7'h01, 7'h02, 7'h33, 7'h75, 7'h76, 7'h77, 7'h7F};
	int                         err_count = 0;
	int                         n_checks  = 0;

	always #5 pclk = ~pclk;

	always @(posedge pclk) begin
		if (rreset === 1'b1) begin
			rr_count <= rr_count + 1;
		end
	end

	platform_model platform_model_i (.pclk(pclk), .presetn(presetn), .want(want), .lvl(lvl));

	power_good_and_reset_supervisor power_good_and_reset_supervisor_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .supply_run_ok(lvl[0]),
		.supply_low(lvl[1]), .device_enable_in(lvl[2]), .thermal_trip_n(lvl[3]), .deep_sleep_n(lvl[4]),
		.standby_sleep_n(lvl[5]), .idle_sleep_n(lvl[6]), .crit_temp_shutdown(lvl[7]),
		.ldo_one_always_on(lvl[8]), .rail_good(lvl[14:9]), .rail_fault(lvl[20:15]),
		.suspend_reset_release(susp), .platform_power_ok(plat), .registers_reset(rreset),
		.rail_pwm_forced(forced), .rail_target_mv(mv), .irq(irq));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : test_done

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD at %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			err_count++;
			test_done();
		end
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wrchk(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
		check(e, 1'b0);
	endtask : wrchk

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, q, e);
		check(q, exp);
		check(e, 1'b0);
	endtask : rdchk

	// Waits out the model edge, two synchroniser edges and the output flop.
	task automatic set_lvl(input logic [20:0] w);
		@(posedge pclk);
		want <= w;
		repeat (4) @(posedge pclk);
		#1;
	endtask : set_lvl

	task automatic cause(input logic [20:0] flip, input logic [20:0] base, input logic hit);
		int start;
		set_lvl(base);
		wrchk(ADDR_FAULT_MASK, 32'h0000_0001);
		start = rr_count;
		set_lvl(base ^ flip);
		set_lvl(base);
		rdchk(ADDR_FAULT_MASK, hit ? 32'h0000_0000 : 32'h0000_0001);
		check(rr_count != start, hit);
	endtask : cause

	function automatic logic [1:0] exp_pg(input logic [20:0] w);
		logic s;
		s = w[0] & ~w[1] & w[2] & w[3] & w[9] & w[12] & w[13] & ~w[7] & (w[20:15] == 6'h00);
		return {s & w[4] & w[5] & (w[14:9] == 6'h3F), s};
	endfunction : exp_pg

	function automatic logic [10:0] exp_mv(input logic [6:0] c);
		if (c == 7'h00) begin
			return 11'h000;
		end
		return (c >= 7'h76) ? 11'd1670 : 11'(500 + 10 * (c - 1));
	endfunction : exp_mv

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		logic [31:0] q;
		logic        e;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		#1;
		check({susp, plat, rreset, irq, forced}, 0);
		rdchk(ADDR_FAULT_MASK, 0);
		rdchk(ADDR_IRQ_ENABLE, 0);
		rdchk(ADDR_RAIL_BASE + 8'h08, 0);
		apb(1'b0, 8'h18, 32'h0000_0000, q, e);
		check(e, 1'b1);
		check(q, 32'h0000_0000);
		set_lvl(good_w);
		check({plat, susp}, 2'b11);
		rdchk(ADDR_STATUS, 32'h0000_3FFF);
		for (int b = 0; b < 21; b++) begin
			if (b != 8) begin
				set_lvl(good_w ^ (21'h1 << b));
				check({plat, susp}, exp_pg(good_w ^ (21'h1 << b)));
				set_lvl(good_w);
				check({plat, susp}, 2'b11);
			end
		end
		check(irq, 1'b0);
		cause(21'h0_0002, good_w, 1'b1);
		cause(21'h0_0004, good_w, 1'b1);
		cause(21'h0_0004, 21'h0_7F7D, 1'b0);
		cause(21'h0_0008, good_w, 1'b1);
		cause(21'h0_0008, 21'h0_7C7D, 1'b0);
		cause(21'h0_0080, good_w, 1'b1);
		cause(21'h1_0000, good_w, 1'b1);
		cause(21'h0_8000, good_w, 1'b0);
		set_lvl(good_w);
		for (int d = 0; d < 2; d++) begin
			wrchk(ADDR_FAULT_MASK, 32'h0000_0001);
			wrchk(ADDR_SHUTDOWN, 32'(d));
			repeat (2) @(posedge pclk);
			rdchk(ADDR_FAULT_MASK, 32'(1 - d));
		end
		for (int r = 0; r < 6; r++) begin
			wrchk(ADDR_RAIL_BASE + 8'(4 * r), 32'h0000_0080);
		end
		repeat (2) @(posedge pclk);
		check(forced, 6'h3C);
		rdchk(ADDR_RAIL_BASE, 0);
		rdchk(ADDR_RAIL_BASE + 8'h08, 32'h0000_0080);
		wrchk(ADDR_RAIL_BASE + 8'h08, 0);
		repeat (2) @(posedge pclk);
		check(forced, 6'h38);
		for (int c = 0; c < 8; c++) begin
			for (int r = 0; r < 4; r++) begin
				wrchk(ADDR_RAIL_BASE + 8'(4 * (r < 2 ? r : r + 2)), {25'h0, codes[c]});
				repeat (2) @(posedge pclk);
				check(mv[r], exp_mv(codes[c]));
			end
		end
		wrchk(ADDR_IRQ_ENABLE, 32'h0000_0004);
		for (int k = 0; k < 2; k++) begin
			for (int r = 0; r < 3; r++) begin
				wrchk(ADDR_RAIL_BASE + 8'(4 * (r < 2 ? r : 4)), 32'h0000_0033);
			end
			set_lvl(good_w ^ (k == 0 ? 21'h0_0040 : 21'h0_0020));
			set_lvl(good_w);
			check(irq, 1'b1);
			rdchk(ADDR_IRQ_STATUS, k == 0 ? 32'h0000_0004 : 32'h0000_0006);
			rdchk(ADDR_RAIL_BASE, 0);
			rdchk(ADDR_RAIL_BASE + 8'h04, 0);
			rdchk(ADDR_RAIL_BASE + 8'h10, 32'h0000_0033);
			check(mv[0], 0);
			wrchk(ADDR_IRQ_CLEAR, 32'h0000_0004);
			repeat (3) @(posedge pclk);
			check(irq, 1'b0);
		end
		// The clear lands on the very edge that sees the idle fall, so the sticky bit must survive.
		@(posedge pclk);
		want <= good_w ^ 21'h0_0040;
		@(posedge pclk);
		wrchk(ADDR_IRQ_CLEAR, 32'h0000_0004);
		set_lvl(good_w);
		rdchk(ADDR_IRQ_STATUS, 32'h0000_0006);
		check(irq, 1'b1);
		test_done();
	end
endmodule : testbench
